// [rtl/bsc_pkg.sv]
// bandwidth and sweep coupling: shared constants, types and table helper
// assumes one 10 MHz clock and a word-wide register port with strobes
// Notes on behaviour
// - preset: coupling on, span 40 MHz, bandwidths 30 kHz, sweep 0.2 s
// - coupling set by preset, toggled by each press of its key
// - bandwidth hold toggles on each press of its key
// - bandwidth preset restores optima, clears offsets, coupled or not
// - under hold, bandwidth preset restores video and sweep only
// - coupled, resolution change recomputes video; video never alters resolution
// - coupled, no hold: resolution follows span, never the reverse
// - optimum resolution bandwidth from span by the threshold ladder
// - optimum video one step above resolution, 30 kHz at the top
// - operator resolution offset stored and reapplied after span changes
// - coupled resolution clamped 3 Hz to 30 kHz, offset kept
// - video offset kept, coupled video clamped 1 Hz to 30 kHz
// - under hold bandwidths ignore span, take entries, video coupled
// - optimum sweep from span and bandwidths; wider or narrower, longer
// - sweep changes never alter span or bandwidths
// - sweep time never below 0.2 s
// - indicator lit while sweep time is below optimum
// - stepped sweep kept as signed offset from optimum
// - numeric sweep entry kept until span or a bandwidth changes while coupled
// - on that change offset becomes rounded log2 of entry over optimum
// - coupled sweep is optimum times two to the offset
// - bandwidth ranges 3 Hz/1 Hz to 30 kHz in 1-3-10 index steps
`default_nettype none

package bsc_pkg;
    // register byte addresses
    localparam logic [7:0] A_CMD  = 8'h00;
    localparam logic [7:0] A_SPAN = 8'h04;
    localparam logic [7:0] A_RES  = 8'h08;
    localparam logic [7:0] A_VID  = 8'h0C;
    localparam logic [7:0] A_SWP  = 8'h10;
    localparam logic [7:0] A_STEP = 8'h14;
    localparam logic [7:0] A_OPT  = 8'h18;
    localparam logic [7:0] A_OFF  = 8'h1C;
    // command bits and step fields
    localparam int C_PRESET = 0;
    localparam int C_COUPLE = 1;
    localparam int C_HOLD   = 2;
    localparam int C_BWPRE  = 3;
    localparam int S_UP     = 4;
    localparam logic [1:0] T_RES = 2'h1;
    localparam logic [1:0] T_VID = 2'h2;
    localparam logic [1:0] T_SWP = 2'h3;
    // bandwidth indices: 0 = 1 Hz, 1 = 3 Hz ... 9 = 30 kHz
    localparam logic [3:0] RES_MIN = 4'h1;
    localparam logic [3:0] VID_MIN = 4'h0;
    localparam logic [3:0] BW_MAX  = 4'h9;
    localparam logic [3:0] PRE_BW  = 4'h9;
    // span in 0.1 Hz units, sweep time in ms
    localparam logic [31:0] SPAN_PRESET = 32'h17D78400;
    localparam logic [31:0] SWP_MIN_MS  = 32'h000000C8;
    localparam int THR_N = 8;
    localparam logic [31:0] SPAN_THR [THR_N] = '{
        32'h000007D0, 32'h00002710, 32'h0000C350, 32'h00030D40,
        32'h000F4240, 32'h004C4B40, 32'h01312D00, 32'h05F5E100};
    // sweep offsets and rounding (181/128 ~ sqrt 2)
    localparam logic signed [5:0] OFF_MIN = 6'sh30;
    localparam logic signed [5:0] OFF_MAX = 6'sh0F;
    localparam int RND_NUM = 181;
    // optimum sweep ms = span * SWP_K / (bw product), fixed point
    localparam int SUM_N   = 19;
    localparam int MULT_SH = 24;
    localparam longint SWP_K = 400;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_RUN  = 2'b01,
        CV_DONE = 2'b10
    } bsc_conv_t;

    // reciprocal of the bandwidth product for index sum s
    function automatic longint swp_mult(input int s);
        longint p;
        p = (s % 2 == 1) ? 64'sh3 : 64'sh1;
        for (int i = 0; i < s / 2; i++) p = p * 10;
        return (SWP_K << MULT_SH) / p;
    endfunction
endpackage

`default_nettype wire

// [rtl/bsc_core.sv]
// bandwidth and sweep-time coupling core with its register port
// assumes strobes synchronous to clk_i, one access per cycle at most
`default_nettype none

module bsc_core (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    // settings toward filters and sweep
    output logic      [3:0]  resolution_bandwidth_o,
    output logic      [3:0]  video_bandwidth_o,
    output logic      [31:0] sweep_time_o,
    output logic      [31:0] span_o,
    output logic             coupling_o,
    output logic             bandwidth_hold_o,
    output logic             uncalibrated_indicator_o
);

////////////////////////////////////////////////////////////////////////
    default clocking cb_main @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic              coupling_r;
    logic              bw_hold_r;
    logic [31:0]       span_r;
    logic [3:0]        resbw_r;
    logic [3:0]        resbw_nxt;
    logic [3:0]        vidbw_r;
    logic [3:0]        vidbw_nxt;
    logic signed [5:0] resbw_off_r;
    logic signed [5:0] resbw_off_nxt;
    logic signed [5:0] vidbw_off_r;
    logic signed [5:0] vidbw_off_nxt;
    logic [31:0]       swp_ms_r;
    logic [31:0]       swp_opt_r;
    logic [31:0]       swp_entry_r;
    logic signed [5:0] swp_off_r;
    logic              swp_num_r;
    logic [1:0]        reopt_r;
    logic              uncalibrated_r;
    logic [31:0]       rd_data_r;
    bsc_pkg::bsc_conv_t conv_state_r;
    logic [71:0]       conv_thr_r;
    logic signed [5:0] conv_k_r;

    logic wr_cmd, wr_span, wr_res, wr_vid, wr_swp, wr_step;
    logic cmd_preset, cmd_couple, cmd_hold, cmd_bwpre;
    logic step_res, step_vid, step_swp, step_up;
    logic res_ok, vid_ok, auto_res, bw_change, conv_go, conv_abort;
    logic [3:0]  opt_res;
    logic [3:0]  vid_target;
    logic [7:0]  thr_hit;
    logic [39:0] mult_tab [bsc_pkg::SUM_N];
    logic [3:0]  eff_bw;
    logic [4:0]  bw_sum;
    logic [71:0] opt_prod;
    logic [31:0] opt_comb;
    logic [63:0] swp_wide;
    logic [5:0]  swp_neg;
    logic [31:0] swp_cpl;
    logic [31:0] entry_clip;
    logic [31:0] swp_dbl;
    logic [31:0] swp_half;
    logic signed [5:0] swp_off_step;
    logic [71:0] conv_lhs;
    logic [31:0] rd_mux;

    function automatic logic signed [6:0] sx(input logic [3:0] a);
        return $signed({3'h0, a});
    endfunction

    function automatic logic signed [6:0] sx6(input logic signed [5:0] a);
        return $signed({a[5], a});
    endfunction

    function automatic logic [3:0] bw_clamp(input logic signed [6:0] v,
                                            input logic [3:0] lo);
        if (v < sx(lo)) return lo;
        if (v > sx(bsc_pkg::BW_MAX)) return bsc_pkg::BW_MAX;
        return v[3:0];
    endfunction

    function automatic logic [3:0] vid_opt(input logic [3:0] r);
        return (r >= bsc_pkg::BW_MAX) ? bsc_pkg::BW_MAX : r + 4'h1;
    endfunction

////////////////////////////////////////////////////////////////////////
    // decode; preset wins over the other command bits
    assign wr_cmd     = wr_i && (addr_i == bsc_pkg::A_CMD);
    assign wr_span    = wr_i && (addr_i == bsc_pkg::A_SPAN);
    assign wr_res     = wr_i && (addr_i == bsc_pkg::A_RES) && res_ok;
    assign wr_vid     = wr_i && (addr_i == bsc_pkg::A_VID) && vid_ok;
    assign wr_swp     = wr_i && (addr_i == bsc_pkg::A_SWP);
    assign wr_step    = wr_i && (addr_i == bsc_pkg::A_STEP);
    assign cmd_preset = wr_cmd && wr_data_i[bsc_pkg::C_PRESET];
    assign cmd_couple = wr_cmd && wr_data_i[bsc_pkg::C_COUPLE] && !cmd_preset;
    assign cmd_hold   = wr_cmd && wr_data_i[bsc_pkg::C_HOLD] && !cmd_preset;
    assign cmd_bwpre  = wr_cmd && wr_data_i[bsc_pkg::C_BWPRE] && !cmd_preset;
    assign step_up    = wr_data_i[bsc_pkg::S_UP];
    assign step_res   = wr_step && (wr_data_i[1:0] == bsc_pkg::T_RES);
    assign step_vid   = wr_step && (wr_data_i[1:0] == bsc_pkg::T_VID);
    assign step_swp   = wr_step && (wr_data_i[1:0] == bsc_pkg::T_SWP);
    // numeric bandwidth entries outside the index range are ignored
    assign res_ok = (wr_data_i[31:4] == 28'h0)
                 && (wr_data_i[3:0] >= bsc_pkg::RES_MIN)
                 && (wr_data_i[3:0] <= bsc_pkg::BW_MAX);
    assign vid_ok = (wr_data_i[31:4] == 28'h0)
                 && (wr_data_i[3:0] <= bsc_pkg::BW_MAX);
    assign auto_res = coupling_r && !bw_hold_r;

////////////////////////////////////////////////////////////////////////
    // optimum resolution index: one step per span threshold passed
    for (genvar g = 0; g < bsc_pkg::THR_N; g++) begin : g_thr
        assign thr_hit[g] = (span_r >= bsc_pkg::SPAN_THR[g]);
    end

    always_comb begin
        opt_res = bsc_pkg::RES_MIN;
        for (int i = 0; i < bsc_pkg::THR_N; i++) begin
            opt_res = opt_res + {3'h0, thr_hit[i]};
        end
    end

    for (genvar g = 0; g < bsc_pkg::SUM_N; g++) begin : g_mult
        assign mult_tab[g] = 40'(bsc_pkg::swp_mult(g));
    end

    // video bandwidth only lengthens the sweep when below resolution
    always_comb begin
        eff_bw = (vidbw_r < resbw_r) ? vidbw_r : resbw_r;
        bw_sum = {1'b0, resbw_r} + {1'b0, eff_bw};
        opt_prod = {40'h0, span_r} * {32'h0, mult_tab[bw_sum]};
        if (|opt_prod[71:56]) opt_comb = 32'hFFFFFFFF;
        else opt_comb = opt_prod[55:24];
        if (opt_comb < bsc_pkg::SWP_MIN_MS) begin
            opt_comb = bsc_pkg::SWP_MIN_MS;
        end
    end

    always_comb begin
        swp_neg = 6'(-swp_off_r);
        swp_wide = {32'h0, swp_opt_r};
        if (swp_off_r[5]) swp_wide = swp_wide >> swp_neg;
        else swp_wide = swp_wide << swp_off_r;
        swp_cpl = (|swp_wide[63:32]) ? 32'hFFFFFFFF : swp_wide[31:0];
        if (swp_cpl < bsc_pkg::SWP_MIN_MS) swp_cpl = bsc_pkg::SWP_MIN_MS;
    end

////////////////////////////////////////////////////////////////////////
    always_comb begin
        resbw_nxt = resbw_r;
        resbw_off_nxt = resbw_off_r;
        if (auto_res) begin
            resbw_nxt = bw_clamp(sx(opt_res) + sx6(resbw_off_r),
                                 bsc_pkg::RES_MIN);
        end
        if (cmd_preset) begin
            resbw_nxt = bsc_pkg::PRE_BW;
            resbw_off_nxt = '0;
        end else if (cmd_bwpre && !bw_hold_r) begin
            resbw_nxt = opt_res;
            resbw_off_nxt = '0;
        end else if (wr_res || step_res) begin
            if (wr_res) resbw_nxt = wr_data_i[3:0];
            else resbw_nxt = bw_clamp(sx(resbw_r) +
                                      (step_up ? 7'sh01 : 7'sh7F),
                                      bsc_pkg::RES_MIN);
            resbw_off_nxt = 6'(sx(resbw_nxt) - sx(opt_res));
        end
    end

    always_comb begin
        vid_target = vid_opt(resbw_nxt);
        vidbw_nxt = vidbw_r;
        vidbw_off_nxt = vidbw_off_r;
        if (coupling_r) begin
            vidbw_nxt = bw_clamp(sx(vid_target) + sx6(vidbw_off_r),
                                 bsc_pkg::VID_MIN);
        end
        if (cmd_preset) begin
            vidbw_nxt = bsc_pkg::PRE_BW;
            vidbw_off_nxt = '0;
        end else if (cmd_bwpre) begin
            vidbw_nxt = vid_target;
            vidbw_off_nxt = '0;
        end else if (wr_vid || step_vid) begin
            if (wr_vid) vidbw_nxt = wr_data_i[3:0];
            else vidbw_nxt = bw_clamp(sx(vidbw_r) +
                                      (step_up ? 7'sh01 : 7'sh7F),
                                      bsc_pkg::VID_MIN);
            vidbw_off_nxt = 6'(sx(vidbw_nxt) - sx(vid_target));
        end
    end

    // span only moves by its own register or by preset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            span_r <= bsc_pkg::SPAN_PRESET;
        end else if (cmd_preset) begin
            span_r <= bsc_pkg::SPAN_PRESET;
        end else if (wr_span) begin
            span_r <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            coupling_r <= 1'b1;
            bw_hold_r  <= 1'b0;
        end else if (cmd_preset) begin
            coupling_r <= 1'b1;
            bw_hold_r  <= 1'b0;
        end else begin
            if (cmd_couple) coupling_r <= !coupling_r;
            if (cmd_hold) bw_hold_r <= !bw_hold_r;
        end
    end

    // uncoupled, the next values equal the current ones unless entered, preset or bandwidth preset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            resbw_r     <= bsc_pkg::PRE_BW;
            resbw_off_r <= '0;
            vidbw_r     <= bsc_pkg::PRE_BW;
            vidbw_off_r <= '0;
        end else begin
            resbw_r     <= resbw_nxt;
            resbw_off_r <= resbw_off_nxt;
            vidbw_r     <= vidbw_nxt;
            vidbw_off_r <= vidbw_off_nxt;
        end
    end

////////////////////////////////////////////////////////////////////////
    assign bw_change  = wr_span || (resbw_nxt != resbw_r)
                     || (vidbw_nxt != vidbw_r);
    assign conv_abort = cmd_preset || wr_swp || step_swp || cmd_bwpre;
    assign conv_go    = swp_num_r && coupling_r && bw_change && !conv_abort;
    assign conv_lhs   = {17'h0, swp_entry_r, 23'h0};
    assign entry_clip = (wr_data_i < bsc_pkg::SWP_MIN_MS) ?
                        bsc_pkg::SWP_MIN_MS : wr_data_i;
    assign swp_dbl  = swp_ms_r[31] ? 32'hFFFFFFFF : {swp_ms_r[30:0], 1'b0};
    assign swp_half = ({1'b0, swp_ms_r[31:1]} < bsc_pkg::SWP_MIN_MS) ?
                      bsc_pkg::SWP_MIN_MS : {1'b0, swp_ms_r[31:1]};
    always_comb begin
        swp_off_step = swp_off_r;
        if (step_up && swp_off_r != bsc_pkg::OFF_MAX) begin
            swp_off_step = swp_off_r + 6'sh01;
        end else if (!step_up && swp_off_r != bsc_pkg::OFF_MIN) begin
            swp_off_step = swp_off_r - 6'sh01;
        end
    end

    // optimum registered; it lags the settings by one cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            swp_opt_r <= bsc_pkg::SWP_MIN_MS;
            reopt_r   <= 2'h0;
        end else begin
            swp_opt_r <= opt_comb;
            reopt_r   <= {reopt_r[0], cmd_bwpre && !coupling_r};
        end
    end

    // rounded log2 search: the entry is compared against ref*sqrt2*2^k,
    // k rising from the lowest offset; the reference is the optimum
    // in force before the change that started it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_state_r <= bsc_pkg::CV_IDLE;
            conv_thr_r   <= '0;
            conv_k_r     <= '0;
        end else if (conv_abort) begin
            conv_state_r <= bsc_pkg::CV_IDLE;
        end else begin
            case (conv_state_r)
                bsc_pkg::CV_IDLE: begin
                    if (conv_go) begin
                        conv_thr_r <= {40'h0, swp_opt_r}
                                    * 72'(bsc_pkg::RND_NUM);
                        conv_k_r <= bsc_pkg::OFF_MIN;
                        conv_state_r <= bsc_pkg::CV_RUN;
                    end
                end
                bsc_pkg::CV_RUN: begin
                    if (conv_lhs < conv_thr_r
                        || conv_k_r == bsc_pkg::OFF_MAX) begin
                        conv_state_r <= bsc_pkg::CV_DONE;
                    end else begin
                        conv_thr_r <= {conv_thr_r[70:0], 1'b0};
                        conv_k_r <= conv_k_r + 6'sh01;
                    end
                end
                bsc_pkg::CV_DONE: begin
                    conv_state_r <= bsc_pkg::CV_IDLE;
                end
                default: begin
                    conv_state_r <= bsc_pkg::CV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            swp_ms_r    <= bsc_pkg::SWP_MIN_MS;
            swp_entry_r <= bsc_pkg::SWP_MIN_MS;
            swp_off_r   <= '0;
            swp_num_r   <= 1'b0;
        end else if (cmd_preset) begin
            swp_ms_r  <= bsc_pkg::SWP_MIN_MS;
            swp_off_r <= '0;
            swp_num_r <= 1'b0;
        end else if (wr_swp) begin
            swp_ms_r    <= entry_clip;
            swp_entry_r <= entry_clip;
            swp_num_r   <= 1'b1;
        end else if (step_swp) begin
            swp_off_r <= swp_off_step;
            swp_num_r <= 1'b0;
            if (!coupling_r) swp_ms_r <= step_up ? swp_dbl : swp_half;
        end else if (cmd_bwpre) begin
            swp_off_r <= '0;
            swp_num_r <= 1'b0;
        end else if (conv_state_r == bsc_pkg::CV_DONE) begin
            swp_off_r <= conv_k_r;
            swp_num_r <= 1'b0;
        end else if (coupling_r && !swp_num_r) begin
            swp_ms_r <= swp_cpl;
        end else if (reopt_r[1] && !swp_num_r) begin
            swp_ms_r <= swp_opt_r;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            uncalibrated_r <= 1'b0;
        end else begin
            uncalibrated_r <= (swp_ms_r < swp_opt_r);
        end
    end

////////////////////////////////////////////////////////////////////////
    always_comb begin
        case (addr_i)
            bsc_pkg::A_CMD:  rd_mux = {27'h0,
                                       conv_state_r != bsc_pkg::CV_IDLE,
                                       uncalibrated_r, swp_num_r,
                                       bw_hold_r, coupling_r};
            bsc_pkg::A_SPAN: rd_mux = span_r;
            bsc_pkg::A_RES:  rd_mux = {18'h0, resbw_off_r, 4'h0, resbw_r};
            bsc_pkg::A_VID:  rd_mux = {18'h0, vidbw_off_r, 4'h0, vidbw_r};
            bsc_pkg::A_SWP:  rd_mux = swp_ms_r;
            bsc_pkg::A_OPT:  rd_mux = swp_opt_r;
            bsc_pkg::A_OFF:  rd_mux = {26'h0, swp_off_r};
            default:         rd_mux = 32'h0;
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) rd_data_r <= 32'h0;
        else rd_data_r <= rd_i ? rd_mux : 32'h0;
    end

    assign rd_data_o                = rd_data_r;
    assign resolution_bandwidth_o   = resbw_r;
    assign video_bandwidth_o        = vidbw_r;
    assign sweep_time_o             = swp_ms_r;
    assign span_o                   = span_r;
    assign coupling_o               = coupling_r;
    assign bandwidth_hold_o         = bw_hold_r;
    assign uncalibrated_indicator_o = uncalibrated_r;

////////////////////////////////////////////////////////////////////////
    a_preset_state: assert property (
        cmd_preset |=> coupling_r && !bw_hold_r
            && span_r == bsc_pkg::SPAN_PRESET && resbw_r == bsc_pkg::PRE_BW
            && vidbw_r == bsc_pkg::PRE_BW
            && swp_ms_r == bsc_pkg::SWP_MIN_MS && !swp_num_r)
        else $error("preset did not load preset settings");
    a_couple_toggle: assert property (
        cmd_couple |=> coupling_r != $past(coupling_r))
        else $error("coupling key did not toggle");
    a_hold_toggle: assert property (
        cmd_hold |=> bw_hold_r != $past(bw_hold_r))
        else $error("hold key did not toggle");
    a_bwpre_clear: assert property (
        cmd_bwpre && !bw_hold_r |=> resbw_off_r == 6'sh00
            && vidbw_off_r == 6'sh00 && swp_off_r == 6'sh00
            && resbw_r == $past(opt_res))
        else $error("bandwidth preset left an offset");
    a_hold_keeps_res: assert property (
        bw_hold_r && !cmd_preset && !wr_res && !step_res
            |=> $stable(resbw_r))
        else $error("resolution moved under hold");
    a_bw_range: assert property (
        resbw_r >= bsc_pkg::RES_MIN && resbw_r <= bsc_pkg::BW_MAX
            && vidbw_r <= bsc_pkg::BW_MAX)
        else $error("bandwidth index out of range");
    a_swp_floor: assert property (
        swp_ms_r >= bsc_pkg::SWP_MIN_MS && swp_opt_r >= bsc_pkg::SWP_MIN_MS)
        else $error("sweep time below minimum");
    a_num_kept: assert property (
        swp_num_r && !conv_abort && conv_state_r != bsc_pkg::CV_DONE
            |=> $stable(swp_ms_r))
        else $error("numeric sweep time not kept");
    a_conv_bound: assert property (
        conv_state_r == bsc_pkg::CV_IDLE && conv_go
            |=> ##[1:33] conv_state_r != bsc_pkg::CV_RUN)
        else $error("sweep conversion overran");
    a_off_step: assert property (
        step_swp && step_up && swp_off_r != bsc_pkg::OFF_MAX
            |=> swp_off_r == 6'($past(swp_off_r) + 6'sh01))
        else $error("sweep step offset wrong");
    // both ways: lit exactly when the sweep was below optimum
    a_uncalibrated_indicator_cause: assert property (
        uncalibrated_r == ($past(swp_ms_r) < $past(swp_opt_r)))
        else $error("indicator does not follow fast sweep");

endmodule

`default_nettype wire

// [tb/bsc_op_model.sv]
// operator keys and entries, acting as master on the register port
// assumes the bench calls put and ask from its one sequence
`default_nettype none
module bsc_op_model (
    input  wire logic        clk_i,
    output logic      [7:0]  addr_o,
    output logic      [31:0] wdat_o,
    output logic             wr_o,
    output logic             rd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {addr_o, wdat_o, wr_o, rd_o} = '0;
    // released data is inverted so a stale value never looks valid
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {addr_o, wdat_o, wr_o} <= {a, d, 1'b1};
        @(posedge clk_i);
        {wdat_o, wr_o} <= {~d, 1'b0};
    endtask
    task automatic ask(input logic [7:0] a);
        @(posedge clk_i);
        {addr_o, rd_o} <= {a, 1'b1};
        @(posedge clk_i);
        rd_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [tb/bsc_core_tb_top.sv]
// self-checking bench for the coupling core
// assumes the operator model is compiled first
`default_nettype none
module bsc_core_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [7:0]  a;
    logic [31:0] wd, rdat, swp, span;
    logic        wr, rd, cpl, hold, unc;
    logic [3:0]  res, vid;
    int          error_cnt = 0;
    int          total_checks = 0;
    bsc_op_model M (.clk_i(clk_i), .addr_o(a), .wdat_o(wd), .wr_o(wr),
        .rd_o(rd));
    bsc_core DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(a),
        .wr_data_i(wd), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat),
        .resolution_bandwidth_o(res), .video_bandwidth_o(vid),
        .sweep_time_o(swp), .span_o(span), .coupling_o(cpl),
        .bandwidth_hold_o(hold), .uncalibrated_indicator_o(unc));
    initial forever #50 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////
    task automatic cs(string n, logic [31:0] e, logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
            error_cnt++;
        end
    endtask
    // 60 cycles covers the longest follow, a sweep conversion
    task automatic go(logic [7:0] ad, logic [31:0] d);
        M.put(ad, d);
        repeat (60) @(posedge clk_i);
        #1;
    endtask
    task automatic bw(logic [3:0] r, logic [3:0] v);
        cs("res", {28'h0, r}, {28'h0, res});
        cs("vid", {28'h0, v}, {28'h0, vid});
    endtask
    task automatic final_report();
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic sc_slip();
        go(8'h04, 32'h00000060);
        bw(4'h1, 4'h2);
        go(8'h04, 32'h000007D0);
        bw(4'h2, 4'h3);
        go(8'h04, 32'h17D78400);
        go(8'h14, 32'h00000001);
        go(8'h14, 32'h00000001);
        bw(4'h7, 4'h8);
        go(8'h04, 32'h00000060);
        bw(4'h1, 4'h2);
        go(8'h04, 32'h17D78400);
        bw(4'h7, 4'h8);
        go(8'h00, 32'h00000008);
        bw(4'h9, 4'h9);
        go(8'h14, 32'h00000002);
        go(8'h04, 32'h00000060);
        bw(4'h1, 4'h1);
        go(8'h04, 32'h17D78400);
        bw(4'h9, 4'h8);
        go(8'h00, 32'h00000008);
    endtask
    task automatic sc_hold();
        go(8'h00, 32'h00000004);
        cs("hold", 32'h1, {31'h0, hold});
        go(8'h04, 32'h00000060);
        bw(4'h9, 4'h9);
        go(8'h14, 32'h00000001);
        go(8'h00, 32'h00000008);
        bw(4'h8, 4'h9);
        go(8'h00, 32'h00000002);
        cs("cpl", 32'h0, {31'h0, cpl});
        go(8'h00, 32'h00000004);
        go(8'h04, 32'h17D78400);
        bw(4'h8, 4'h9);
        go(8'h00, 32'h00000002);
        go(8'h00, 32'h00000008);
        cs("cpl", 32'h1, {31'h0, cpl});
    endtask
    task automatic sc_swp();
        go(8'h14, 32'h00000013);
        cs("swp", 32'h190, swp);
        go(8'h00, 32'h00000008);
        go(8'h10, 32'h00000064);
        cs("swp", 32'hC8, swp);
        go(8'h10, 32'h000003E8);
        cs("swp", 32'h3E8, swp);
        go(8'h04, 32'h0BEBC200);
        cs("swp", 32'h320, swp);
        go(8'h04, 32'h17D78400);
        go(8'h08, 32'h00000005);
        bw(4'h5, 4'h6);
        go(8'h14, 32'h00000003);
        go(8'h14, 32'h00000003);
        cs("unc", 32'h0, {31'h0, unc});
        go(8'h14, 32'h00000003);
        cs("unc", 32'h1, {31'h0, unc});
        M.ask(8'h20);
        #1 cs("rd", 32'h0, rdat);
        M.ask(8'h04);
        #1 cs("rd", 32'h17D78400, rdat);
        @(posedge clk_i);
        #1 cs("rd", 32'h0, rdat);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        go(8'h20, 32'h00000000);
        bw(4'h9, 4'h9);
        cs("span", 32'h17D78400, span);
        cs("swp", 32'hC8, swp);
        sc_slip();
        sc_hold();
        sc_swp();
        final_report();
    end
endmodule
`default_nettype wire
